// ==== src/timer_pkg.sv ====
// shared constants and types of the 8-bit timer compare unit
package timer_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMP_A = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_PORT_CTRL = 8'h1C;
    // field positions
    localparam int CA_WGM_LSB = 0;
    localparam int CA_COMB_LSB = 4;
    localparam int CA_COMA_LSB = 6;
    localparam int CB_CS_LSB = 0;
    localparam int CB_WGM2 = 3;
    localparam int CB_FOCB = 6;
    localparam int CB_FOCA = 7;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_CMPA = 1;
    localparam int PC_DIR_LSB = 0;
    localparam int PC_DATA_LSB = 2;
    // reset values and count limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CB_RW_MASK = 8'h0F;
    // prescaler taps
    localparam int PRE_W = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    // waveform mode codes
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMPA = 3'h5;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

    typedef enum logic [2:0] {
        CS_OFF = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;
endpackage

// ==== src/cmp_chan_if.sv ====
// signals between the counter core and one compare channel
`timescale 1ns/1ps
interface cmp_chan_if;
    logic tick;
    logic block;
    logic force_;
    logic wrEn;
    logic [7:0] wrData;
    logic [1:0] com;
    logic pwm;
    logic phase;
    logic up;
    logic atBottom;
    logic load;
    logic [7:0] cnt;
    logic [7:0] active;
    logic [7:0] readVal;
    logic match;
    logic ocState;
    modport ctrl(output tick, block, force_, wrEn, wrData, com, pwm, phase,
        up, atBottom, load, cnt, input active, readVal, match, ocState);
    modport chan(input tick, block, force_, wrEn, wrData, com, pwm, phase,
        up, atBottom, load, cnt, output active, readVal, match, ocState);
endinterface

// ==== src/compare_channel.sv ====
// one output compare channel: buffered compare value and output state
`timescale 1ns/1ps
module compare_channel #(
    parameter bit TOGGLE_PWM = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // link to counter core
    cmp_chan_if.chan ch
);
    import timer_pkg::*;

    typedef struct packed {
        logic [7:0] active;
        logic [7:0] buffer;
        logic oc;
    } chan_state_t;

    chan_state_t st_r;
    chan_state_t st_nxt;
    logic hit;
    logic act;

    always_comb begin
        st_nxt = st_r;
        hit = ch.tick && !ch.block && (ch.cnt == st_r.active); // R10 R16
        act = hit || (ch.force_ && !ch.pwm); // R15
        if (ch.wrEn) begin
            if (ch.pwm) begin
                st_nxt.buffer = ch.wrData; // R14
            end else begin
                st_nxt.active = ch.wrData; // R12 R14
                st_nxt.buffer = ch.wrData;
            end
        end
        if (ch.load && ch.pwm) begin
            st_nxt.active = st_r.buffer; // R13
        end
        // com of zero falls to default everywhere: state untouched
        if (!ch.pwm) begin
            if (act) begin
                case (ch.com) // R18 R25
                    2'd1: st_nxt.oc = !st_r.oc;
                    2'd2: st_nxt.oc = 1'b0;
                    2'd3: st_nxt.oc = 1'b1;
                    default: st_nxt.oc = st_r.oc;
                endcase
            end
        end else if (ch.phase) begin
            if (hit) begin
                case (ch.com)
                    2'd1: st_nxt.oc = TOGGLE_PWM ? !st_r.oc : st_r.oc;
                    2'd2: st_nxt.oc = !ch.up;
                    2'd3: st_nxt.oc = ch.up;
                    default: st_nxt.oc = st_r.oc;
                endcase
            end
        end else begin
            if (hit) begin
                case (ch.com)
                    2'd1: st_nxt.oc = TOGGLE_PWM ? !st_r.oc : st_r.oc;
                    2'd2: st_nxt.oc = 1'b0;
                    2'd3: st_nxt.oc = 1'b1;
                    default: st_nxt.oc = st_r.oc;
                endcase
            end
            // bottom wins so a compare value at top gives a flat level
            if (ch.atBottom) begin
                case (ch.com)
                    2'd2: st_nxt.oc = 1'b1;
                    2'd3: st_nxt.oc = 1'b0;
                    default: st_nxt.oc = st_nxt.oc;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0; // R19
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.active = st_r.active;
    assign ch.readVal = ch.pwm ? st_r.buffer : st_r.active; // R14
    assign ch.match = hit;
    assign ch.ocState = st_r.oc;
endmodule

// ==== src/eight_bit_timer_compare_unit.sv ====
// 8-bit timer/counter with two compare channels behind an APB slave
//
// Behaviour
// R1: count value and both compare values are 8-bit registers.
// R2: every interrupt request is a flag, each masked by its own bit.
// R3: tick from prescaler or external pin, chosen by three-bit select.
// R4: select zero gives no tick; counter neither counts nor clears.
// R5: software reads and writes the count value at any time.
// R6: a software count write beats a simultaneous clear or count.
// R7: each tick clears the counter or steps it up or down by one.
// R8: waveform mode field: two low bits in control A, high bit in B.
// R9: overflow flag set where the mode says; unmasked, it requests.
// R10: counter equal to compare value sets that flag on the tick.
// R11: compare flag clears on service or on writing one to it.
// R12: compare values double-buffered in PWM modes, direct otherwise.
// R13: buffered compare value copied only at top or bottom.
// R14: software reaches the buffer when buffering, else the active value.
// R15: force strobe acts as a match on the output, no flag or clear; the code ignores it in PWM modes.
// R16: any count write suppresses matches in the next tick cycle.
// R17: output compare state survives waveform mode changes.
// R18: compare output mode changes act at once, unbuffered.
// R19: reset clears each output compare state to zero.
// R20: nonzero compare output mode puts compare output on the port pin.
// R21: pin direction stays with the port direction bit.
// R22: software should set output state before enabling the pin.
// R23: bottom is 0x00, max 0xFF; top is max or compare A.
// R24: mode 0 normal, 2 clear on A match, 3 or 7 fast PWM.
// R25: compare output mode zero leaves output state on a match.
// R26: reset zeroes count, compare, control, flag and mask registers.
`timescale 1ns/1ps
module eight_bit_timer_compare_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_pkg::DATA_W-1:0] pwdata,
    output logic [timer_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // external count clock
    input wire logic extCountClockPin,
    // interrupts: service acknowledge and requests
    input wire logic [2:0] irqAck,
    output logic [2:0] irqReq,
    // compare pins, index 0 is channel a
    output logic [1:0] cmpPinOut,
    output logic [1:0] cmpPinOeN
);
    import timer_pkg::*;

    typedef struct packed {
        logic [7:0] ctrlA;
        logic [7:0] ctrlB;
        logic [7:0] cnt; // R1
        logic [2:0] mask;
        logic [2:0] flags;
        dir_t dir;
        logic block;
        logic [PRE_W-1:0] pre;
        logic [2:0] extSync;
        logic extLvl;
        logic [1:0] ddr;
        logic [1:0] portVal;
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    cmp_chan_if ch[2] ();

    logic [2:0] wgm;
    clk_sel_t cs;
    logic pwm;
    logic fast;
    logic phase;
    logic [7:0] top;
    logic tick;
    logic loadPulse;
    logic bottomPulse;
    logic ovfSet;
    logic wrAccess;
    logic setupRd;
    logic mapped;
    logic [2:0] flagClr;
    logic [7:0] rdByte;

    always_comb begin
        case (paddr)
            ADDR_CTRL_A, ADDR_CTRL_B, ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B,
            ADDR_IRQ_MASK, ADDR_IRQ_FLAGS, ADDR_PORT_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states; unmapped accesses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wrAccess = psel && penable && pwrite && mapped;
    assign setupRd = psel && !penable && !pwrite;
    assign prdata = st_r.rdata;
    assign irqReq = st_r.flags & st_r.mask; // R2 R9

    always_comb begin
        st_nxt = st_r;
        wgm = {st_r.ctrlB[CB_WGM2], st_r.ctrlA[CA_WGM_LSB +: 2]}; // R8
        cs = clk_sel_t'(st_r.ctrlB[CB_CS_LSB +: 3]);
        fast = (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_CMPA); // R24
        phase = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_CMPA);
        pwm = fast || phase; // R12
        top = (wgm[2] || wgm == WGM_CTC) ? ch[0].active : CNT_MAX; // R23
        loadPulse = 1'b0;
        bottomPulse = 1'b0;
        ovfSet = 1'b0;
        flagClr = irqAck; // R11
        rdByte = RST_BYTE;

        // free prescaler and filtered external pin
        st_nxt.pre = st_r.pre + 1'b1;
        st_nxt.extSync = {st_r.extSync[1:0], extCountClockPin};
        if (st_r.extSync[1] == st_r.extSync[2]) begin
            st_nxt.extLvl = st_r.extSync[2];
        end

        // external edges come three cycles late and need a slow pin
        case (cs) // R3
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (st_r.pre & DIV8_MASK) == DIV8_MASK;
            CS_DIV64: tick = (st_r.pre & DIV64_MASK) == DIV64_MASK;
            CS_DIV256: tick = (st_r.pre & DIV256_MASK) == DIV256_MASK;
            CS_DIV1024: tick = (st_r.pre & DIV1024_MASK) == DIV1024_MASK;
            CS_EXT_FALL: tick = st_r.extLvl && !st_nxt.extLvl;
            CS_EXT_RISE: tick = !st_r.extLvl && st_nxt.extLvl;
            default: tick = 1'b0; // R4
        endcase

        if (!phase) begin
            st_nxt.dir = DIR_UP;
        end

        if (tick) begin // R7
            st_nxt.block = 1'b0;
            if (fast) begin
                if (st_r.cnt == top) begin
                    st_nxt.cnt = CNT_BOTTOM;
                    bottomPulse = 1'b1;
                    loadPulse = 1'b1; // R13
                    ovfSet = 1'b1; // R9
                end else begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end else if (phase) begin
                case (st_r.dir)
                    DIR_UP: begin
                        if (st_r.cnt == top) begin
                            st_nxt.dir = DIR_DOWN;
                            st_nxt.cnt = st_r.cnt - 8'h01;
                            loadPulse = 1'b1; // R13
                        end else begin
                            st_nxt.cnt = st_r.cnt + 8'h01;
                        end
                    end
                    DIR_DOWN: begin
                        if (st_r.cnt == CNT_BOTTOM) begin
                            st_nxt.dir = DIR_UP;
                            st_nxt.cnt = st_r.cnt + 8'h01;
                            ovfSet = 1'b1; // R9
                        end else begin
                            st_nxt.cnt = st_r.cnt - 8'h01;
                        end
                    end
                    default: st_nxt.dir = DIR_UP;
                endcase
            end else begin
                // normal, clear on match, and reserved codes count up
                if (wgm == WGM_CTC && st_r.cnt == top) begin
                    st_nxt.cnt = CNT_BOTTOM; // R24
                end else begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
                ovfSet = (st_r.cnt == CNT_MAX); // R9
            end
        end

        if (wrAccess) begin
            case (paddr)
                ADDR_CTRL_A: st_nxt.ctrlA = pwdata[7:0]; // R17 R18
                ADDR_CTRL_B: st_nxt.ctrlB = pwdata[7:0] & CB_RW_MASK;
                ADDR_COUNT: begin
                    st_nxt.cnt = pwdata[7:0]; // R5 R6
                    st_nxt.block = 1'b1; // R16
                end
                ADDR_IRQ_MASK: st_nxt.mask = pwdata[2:0];
                ADDR_IRQ_FLAGS: flagClr = flagClr | pwdata[2:0]; // R11
                ADDR_PORT_CTRL: begin
                    st_nxt.ddr = pwdata[PC_DIR_LSB +: 2];
                    st_nxt.portVal = pwdata[PC_DATA_LSB +: 2];
                end
                default: st_nxt.mask = st_r.mask;
            endcase
        end

        // a new event beats a clear in the same cycle
        st_nxt.flags = (st_r.flags & ~flagClr)
            | {ch[1].match, ch[0].match, ovfSet}; // R2 R10

        // read data is latched in the setup phase
        case (paddr)
            ADDR_CTRL_A: rdByte = st_r.ctrlA;
            ADDR_CTRL_B: rdByte = st_r.ctrlB;
            ADDR_COUNT: rdByte = st_r.cnt; // R5
            ADDR_CMP_A: rdByte = ch[0].readVal; // R14
            ADDR_CMP_B: rdByte = ch[1].readVal;
            ADDR_IRQ_MASK: rdByte = {5'h00, st_r.mask};
            ADDR_IRQ_FLAGS: rdByte = {5'h00, st_r.flags};
            ADDR_PORT_CTRL: rdByte = {4'h0, st_r.portVal, st_r.ddr};
            default: rdByte = RST_BYTE;
        endcase
        if (setupRd) begin
            st_nxt.rdata = {24'h000000, rdByte};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0; // R26
            st_r.dir <= DIR_UP;
        end else begin
            st_r <= st_nxt;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            localparam int COM_LSB = (i == 0) ? CA_COMA_LSB : CA_COMB_LSB;
            localparam int FOC_BIT = (i == 0) ? CB_FOCA : CB_FOCB;
            localparam logic [7:0] CMP_ADDR =
                (i == 0) ? ADDR_CMP_A : ADDR_CMP_B;

            assign ch[i].tick = tick;
            assign ch[i].block = st_r.block; // R16
            assign ch[i].force_ = wrAccess && (paddr == ADDR_CTRL_B)
                && pwdata[FOC_BIT]; // R15
            assign ch[i].wrEn = wrAccess && (paddr == CMP_ADDR);
            assign ch[i].wrData = pwdata[7:0];
            assign ch[i].com = st_r.ctrlA[COM_LSB +: 2]; // R18
            assign ch[i].pwm = pwm;
            assign ch[i].phase = phase;
            assign ch[i].up = (st_r.dir == DIR_UP);
            assign ch[i].atBottom = bottomPulse;
            assign ch[i].load = loadPulse;
            assign ch[i].cnt = st_r.cnt;

            compare_channel #(
                .TOGGLE_PWM(i == 0)
            ) u_chan (
                .mclk(mclk),
                .nrst(nrst),
                .ch(ch[i])
            );

            // override holds in every waveform mode
            assign cmpPinOut[i] = (ch[i].com != 2'b00)
                ? ch[i].ocState : st_r.portVal[i]; // R20
            assign cmpPinOeN[i] = !st_r.ddr[i]; // R21
        end
    endgenerate
endmodule

// ==== test/timer_unit_assertions.sv ====
// concurrent checks on the timer unit's top-level ports
`timescale 1ns/1ps
module timer_unit_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_pkg::DATA_W-1:0] pwdata,
    input wire logic [timer_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // requests and pins
    input wire logic [2:0] irqReq,
    input wire logic [1:0] cmpPinOut,
    input wire logic [1:0] cmpPinOeN
);
    import timer_pkg::*;
    logic wrAcc;
    logic rdSetup;
    logic csOff_r;
    logic cntKnown_r;
    logic [7:0] cnt_r;
    logic [2:0] mask_r;
    logic [1:0] comOn_r;
    logic [1:0] portData_r;
    assign wrAcc = psel && penable && pwrite && pready;
    assign rdSetup = psel && !penable && !pwrite;
    // shadows only what software wrote; the count is known after reset or after a count write while stopped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            csOff_r <= 1'b1;
            cntKnown_r <= 1'b1;
            cnt_r <= 8'h00;
            mask_r <= 3'h0;
            comOn_r <= 2'b00;
            portData_r <= 2'b00;
        end else if (wrAcc) begin
            if (paddr == ADDR_CTRL_B) begin
                csOff_r <= pwdata[CB_CS_LSB+:3] == 3'h0;
                if (pwdata[CB_CS_LSB+:3] != 3'h0) cntKnown_r <= 1'b0;
            end
            if (paddr == ADDR_COUNT) begin
                cnt_r <= pwdata[7:0];
                cntKnown_r <= csOff_r;
            end
            if (paddr == ADDR_IRQ_MASK) mask_r <= pwdata[2:0];
            if (paddr == ADDR_CTRL_A) comOn_r <= {|pwdata[CA_COMB_LSB+:2],
                |pwdata[CA_COMA_LSB+:2]};
            if (paddr == ADDR_PORT_CTRL) portData_r <= pwdata[PC_DATA_LSB+:2];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_slverr_unmapped: assert property (psel && penable &&
        paddr > ADDR_PORT_CTRL |-> pslverr)
        else $error("unmapped access not refused");
    a_slverr_mapped: assert property (psel && penable &&
        paddr <= ADDR_PORT_CTRL && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (prdata[DATA_W-1:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    a_oe_direction: assert property (wrAcc && paddr == ADDR_PORT_CTRL
        |=> cmpPinOeN == ~$past(pwdata[PC_DIR_LSB+:2]))
        else $error("pin enable does not follow direction bits");
    a_mask_gates: assert property (wrAcc && paddr == ADDR_IRQ_MASK &&
        pwdata[2:0] == 3'h0 |=> irqReq == 3'h0 [*3])
        else $error("request raised while masked");
    a_mask_readback: assert property (rdSetup &&
        paddr == ADDR_IRQ_MASK |=> prdata[7:0] == {5'h00, mask_r})
        else $error("mask read back wrong");
    a_count_stopped: assert property (rdSetup && paddr == ADDR_COUNT &&
        csOff_r && cntKnown_r |=> prdata[7:0] == cnt_r)
        else $error("stopped count changed");
    a_port_override: assert property (
        (~comOn_r & cmpPinOut) == (~comOn_r & portData_r))
        else $error("pin not port value with mode field zero");
endmodule

bind eight_bit_timer_compare_unit timer_unit_assertions u_chk (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irqReq(irqReq),
    .cmpPinOut(cmpPinOut), .cmpPinOeN(cmpPinOeN)
);

// ==== test/ext_count_source.sv ====
// external count clock source: bursts of clean pulses on request
`timescale 1ns/1ps
module ext_count_source (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // request
    input wire logic start,
    input wire logic [7:0] pulseCount,
    // pin and status
    output logic pin,
    output logic busy
);
    logic [7:0] left_r;
    logic [2:0] ph_r;
    assign busy = left_r != 8'h00;
    // four high, four low: wider than the three-flop synchroniser needs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            left_r <= 8'h00;
            ph_r <= 3'h0;
            pin <= 1'b0;
        end else if (start && !busy) begin
            left_r <= pulseCount;
            ph_r <= 3'h0;
        end else if (busy) begin
            pin <= !ph_r[2];
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h7) left_r <= left_r - 8'h01;
        end else begin
            pin <= 1'b0;
        end
    end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the 8-bit timer compare unit
`timescale 1ns/1ps
module tb_top;
    import timer_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] irqAck = 3'h0;
    logic [2:0] irqReq;
    logic [1:0] cmpPinOut;
    logic [1:0] cmpPinOeN;
    logic extPin;
    logic srcBusy;
    logic srcStart = 1'b0;
    logic [7:0] srcCount = 8'h00;
    logic [31:0] rdVal;
    logic errSeen;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #25 mclk = ~mclk;

    eight_bit_timer_compare_unit u_dut (.mclk(mclk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extCountClockPin(extPin), .irqAck(irqAck),
        .irqReq(irqReq), .cmpPinOut(cmpPinOut), .cmpPinOeN(cmpPinOeN));
    ext_count_source u_src (.mclk(mclk), .nrst(nrst), .start(srcStart),
        .pulseCount(srcCount), .pin(extPin), .busy(srcBusy));

    task automatic close_out;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // access phase, then release with one idle cycle
    task automatic acc;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        errSeen = pslverr;
        rdVal = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        acc();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string what);
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge mclk);
        penable <= 1'b1;
        acc();
        chk(what, {24'h0, e}, rdVal);
    endtask

    // pins and requests looked at mid-cycle, once settled
    task automatic outs(input logic [1:0] eo, input logic [1:0] en,
        input logic [2:0] ei);
        @(negedge mclk);
        chk("pin out", 32'(eo), 32'(cmpPinOut));
        chk("pin oe_n", 32'(en), 32'(cmpPinOeN));
        chk("irq req", 32'(ei), 32'(irqReq));
        @(posedge mclk);
    endtask

    // burst on the external pin, then room for the synchroniser
    task automatic pulses(input logic [7:0] n);
        srcCount <= n;
        srcStart <= 1'b1;
        @(posedge mclk);
        srcStart <= 1'b0;
        do begin
            @(negedge mclk);
        end while (srcBusy === 1'b1);
        repeat (6) @(posedge mclk);
    endtask

    task automatic done(input string what);
        $display("test %s done", what);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a <= 28; a += 4) rd(8'(a), 8'h00, "reset reg");
        rd(8'h20, 8'h00, "unmapped read");
        chk("unmapped err", 32'h1, 32'(errSeen));
        outs(2'b00, 2'b11, 3'h0);
        wr(ADDR_COUNT, 8'h5A);
        pulses(8'd4);
        rd(ADDR_COUNT, 8'h5A, "stopped count");
        done("reset and stop");
        wr(ADDR_CTRL_B, 8'h07);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_COUNT, 8'hFE);
        pulses(8'd2);
        rd(ADDR_COUNT, 8'h00, "wrap count");
        rd(ADDR_IRQ_FLAGS, 8'h01, "overflow flag");
        outs(2'b00, 2'b11, 3'h1);
        wr(ADDR_IRQ_MASK, 8'h00);
        outs(2'b00, 2'b11, 3'h0);
        wr(ADDR_IRQ_FLAGS, 8'h01);
        rd(ADDR_IRQ_FLAGS, 8'h00, "write one clear");
        done("normal");
        wr(ADDR_CMP_A, 8'h40);
        rd(ADDR_CMP_A, 8'h40, "direct compare");
        wr(ADDR_COUNT, 8'h40);
        pulses(8'd1);
        rd(ADDR_IRQ_FLAGS, 8'h00, "blocked match");
        wr(ADDR_COUNT, 8'h3F);
        pulses(8'd2);
        rd(ADDR_IRQ_FLAGS, 8'h02, "match flag");
        irqAck <= 3'b010;
        @(posedge mclk);
        irqAck <= 3'b000;
        rd(ADDR_IRQ_FLAGS, 8'h00, "service clear");
        done("match");
        wr(ADDR_CTRL_A, 8'h02);
        wr(ADDR_COUNT, 8'h3E);
        pulses(8'd3);
        rd(ADDR_COUNT, 8'h00, "clear on match");
        rd(ADDR_IRQ_FLAGS, 8'h02, "clear match flag");
        wr(ADDR_IRQ_FLAGS, 8'h07);
        done("clear on match");
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_PORT_CTRL, 8'h0C);
        outs(2'b11, 2'b11, 3'h0);
        wr(ADDR_CTRL_A, 8'h40);
        outs(2'b10, 2'b11, 3'h0);
        wr(ADDR_CTRL_B, 8'hC7);
        outs(2'b11, 2'b11, 3'h0);
        rd(ADDR_IRQ_FLAGS, 8'h00, "force flag");
        rd(ADDR_COUNT, 8'h00, "force count");
        wr(ADDR_CTRL_A, 8'h50);
        outs(2'b01, 2'b11, 3'h0);
        wr(ADDR_PORT_CTRL, 8'h0F);
        outs(2'b01, 2'b00, 3'h0);
        wr(ADDR_CTRL_A, 8'h53);
        outs(2'b01, 2'b00, 3'h0);
        done("force and pins");
        wr(ADDR_CTRL_A, 8'h33);
        wr(ADDR_CTRL_B, 8'h06);
        wr(ADDR_CMP_B, 8'h11);
        rd(ADDR_CMP_B, 8'h11, "buffer read");
        wr(ADDR_COUNT, 8'h0F);
        pulses(8'd3);
        rd(ADDR_IRQ_FLAGS, 8'h00, "no early load");
        wr(ADDR_COUNT, 8'hFE);
        pulses(8'd20);
        rd(ADDR_IRQ_FLAGS, 8'h05, "load at top");
        outs(2'b11, 2'b00, 3'h0);
        done("double buffer");
        close_out();
    end
endmodule
